// [pkg/spi_port_pkg.sv]
package spi_port_pkg;

    // Frame and command word layout
    localparam int         FRAME_BITS    = 24;
    localparam int         CONV_BITS     = 16;
    localparam int         REG_BITS      = 8;
    localparam logic [4:0] REG_CLOCKS    = 5'h18;
    localparam logic [4:0] OPC_WRITE     = 5'h01;
    localparam logic [4:0] OPC_READ      = 5'h02;
    localparam int         OPC_LSB       = 19;
    localparam int         ADDR_LSB      = 8;

    // Device configuration registers and reset values
    localparam logic [10:0] ADDR_IN_CTRL    = 11'h008;
    localparam logic [10:0] ADDR_OUT_CTRL   = 11'h00C;
    localparam int          OUT_WIDTH_BIT   = 2;
    localparam logic [1:0]  PROTO_RESET     = 2'h0;
    localparam logic [1:0]  OUT_PROTO_RESET = 2'h0;
    localparam logic        OUT_WIDTH_RESET = 1'b0;

    // Host serial clock timing
    localparam int PCLK_NS       = 50;
    localparam int SCLK_HALF_NS  = 400;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;

    // Host register map and fields
    localparam logic [7:0] OFS_CMD         = 8'h00;
    localparam logic [7:0] OFS_CTRL        = 8'h04;
    localparam logic [7:0] OFS_STATUS      = 8'h08;
    localparam logic [7:0] OFS_RXDATA      = 8'h0C;
    localparam int         CTRL_DUAL_BIT   = 2;
    localparam int         CTRL_RETIME_BIT = 3;
    localparam int         CTRL_CLK_LSB    = 8;
    localparam int         STAT_BUSY_BIT   = 0;
    localparam int         STAT_DONE_BIT   = 1;

    // Host frame sequencer
    typedef enum logic [1:0] {H_IDLE, H_LEAD, H_CLK, H_TAIL} host_state_t;

endpackage

// [pkg/spi_link_if.sv]
`timescale 1ns/1ns
interface spi_link_if;
    // Host driven
    logic sclk;
    logic cs_n;
    logic sdi;
    // Device driven with enables
    logic primary_output_lane_o;
    logic primary_output_lane_oe;
    logic secondary_output_lane_o;
    logic secondary_output_lane_oe;
    logic ready_o;
    logic ready_oe;
    // Wire levels, weak pull-down when undriven
    logic primary_output_lane;
    logic secondary_output_lane;
    logic ready;
    assign primary_output_lane   = primary_output_lane_oe & primary_output_lane_o;
    assign secondary_output_lane = secondary_output_lane_oe & secondary_output_lane_o;
    assign ready                 = ready_oe & ready_o;

    modport device (
        input  sclk, cs_n, sdi,
        output primary_output_lane_o, primary_output_lane_oe,
        output secondary_output_lane_o, secondary_output_lane_oe,
        output ready_o, ready_oe
    );
    modport host (
        output sclk, cs_n, sdi,
        input  primary_output_lane, secondary_output_lane, ready
    );
endinterface

// [rtl/spi_port_device.sv]
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - four polarity/phase protocols from select field
// - mode 0 after reset for all transfers
// - host changes mode in a frame of the old mode
// - selected protocol also governs read frames
// - register frame valid only with 24 clocks
// - host gives sixteen clocks for conversion reads; this host resets to 24 (REG_CLOCKS), t_conv reads with 24 and t_dual with 12
// - MSB at select fall, modes 0 and 2
// - ready stays low during standard frames
// - default single lane, one bit per edge
// - width bit enables the secondary lane driver
// - dual lane shifts two bits per edge
// - re-timed mode returns clock on ready pin
// - re-timed mode honours the width bit
// - same edge timing, dual halves clocks
// - opcode, address, data; write and read opcodes
// - read byte leads the next frame
module spi_port_device #(
    parameter int BUF_WIDTH = spi_port_pkg::CONV_BITS
) (
    // Serial link
    spi_link_if.device               link,
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Conversion results in
    input  wire logic [BUF_WIDTH-1:0] conv_data,
    input  wire logic                conv_valid,
    output logic                     conv_ready,
    // Programmed configuration
    output logic [1:0]               input_protocol_select,
    output logic [1:0]               output_protocol_select,
    output logic                     output_lane_width
);
    import spi_port_pkg::*;

    logic [2:0]            sclk_sync_ff;
    logic [2:0]            cs_sync_ff;
    logic [1:0]            sdi_sync_ff;
    logic [1:0]            in_mode_ff;
    logic [1:0]            out_mode_ff;
    logic                  width_ff;
    logic [1:0]            frame_mode_ff;
    logic                  frame_dual_ff;
    logic                  frame_retime_ff;
    logic [FRAME_BITS-1:0] sh_ff;
    logic [FRAME_BITS-1:0] rx_ff;
    logic [4:0]            cnt_ff;
    logic                  lane0_ff;
    logic                  lane1_ff;
    logic                  prim_oe_ff;
    logic                  sec_oe_ff;
    logic                  ready_ff;
    logic                  rd_pend_ff;
    logic [REG_BITS-1:0]   rd_byte_ff;
    logic [BUF_WIDTH-1:0]  buf_mem_ff [2];
    logic                  wr_ptr_ff;
    logic                  rd_ptr_ff;
    logic [1:0]            buf_cnt_ff;
    logic                  buf_ready_ff;
    logic                  presetn_q_ff;

    // Shift by one lane or two lanes, MSB first
    function automatic logic [FRAME_BITS-1:0] shift_lanes(
        input logic [FRAME_BITS-1:0] w,
        input logic                  dual
    );
        shift_lanes = dual ? {w[FRAME_BITS-3:0], 2'b00} : {w[FRAME_BITS-2:0], 1'b0};
    endfunction

    // Link pin synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff   <= 3'h7;
            sdi_sync_ff  <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
            cs_sync_ff   <= {cs_sync_ff[1:0], link.cs_n};
            sdi_sync_ff  <= {sdi_sync_ff[0], link.sdi};
        end
    end

    // Edge and frame decode
    wire sclk_rise   = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    wire sclk_fall   = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    wire frame_start = ~cs_sync_ff[1] & cs_sync_ff[2];
    wire frame_end   = cs_sync_ff[1] & ~cs_sync_ff[2];
    wire in_frame    = ~cs_sync_ff[1] & ~cs_sync_ff[2];
    wire cap_on_rise = (frame_mode_ff == 2'h0) || (frame_mode_ff == 2'h3);
    wire cap_edge    = in_frame & (cap_on_rise ? sclk_rise : sclk_fall);
    wire launch_edge = in_frame & (cap_on_rise ? sclk_fall : sclk_rise);
    wire early_msb   = ~in_mode_ff[0];
    wire buf_has     = buf_cnt_ff != 2'h0;

    // Word for the coming frame: pending register byte, else a result
    wire [FRAME_BITS-1:0] conv_word =
        {buf_mem_ff[rd_ptr_ff], {(FRAME_BITS - BUF_WIDTH){1'b0}}};
    wire [FRAME_BITS-1:0] start_word =
        rd_pend_ff ? {rd_byte_ff, {(FRAME_BITS - REG_BITS){1'b0}}}
                   : (buf_has ? conv_word : {FRAME_BITS{1'b0}});
    wire pop = frame_start & ~rd_pend_ff & buf_has;

    // Protocol is frozen at select fall, so a mode write acts next frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_mode_ff   <= PROTO_RESET;
            frame_dual_ff   <= OUT_WIDTH_RESET;
            frame_retime_ff <= 1'b0;
        end else if (frame_start) begin
            frame_mode_ff   <= in_mode_ff;
            frame_dual_ff   <= width_ff;
            frame_retime_ff <= out_mode_ff != 2'h0;
        end
    end

    // Output shifter: early modes show the MSB at select fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff    <= '0;
            lane0_ff <= 1'b0;
            lane1_ff <= 1'b0;
        end else if (frame_start) begin
            sh_ff    <= early_msb ? shift_lanes(start_word, width_ff) : start_word;
            lane0_ff <= early_msb & start_word[FRAME_BITS-1];
            lane1_ff <= early_msb & width_ff & start_word[FRAME_BITS-2];
        end else if (launch_edge) begin
            sh_ff    <= shift_lanes(sh_ff, frame_dual_ff);
            lane0_ff <= sh_ff[FRAME_BITS-1];
            lane1_ff <= frame_dual_ff & sh_ff[FRAME_BITS-2];
        end
    end

    // Drivers are released as soon as select is seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prim_oe_ff <= 1'b0;
            sec_oe_ff  <= 1'b0;
        end else if (frame_start) begin
            prim_oe_ff <= 1'b1;
            sec_oe_ff  <= width_ff;
        end else if (frame_end) begin
            prim_oe_ff <= 1'b0;
            sec_oe_ff  <= 1'b0;
        end
    end

    // Ready: low in standard modes, toggles mid-bit when re-timed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
        end else if (frame_start || frame_end) begin
            ready_ff <= 1'b0;
        end else if (cap_edge && frame_retime_ff) begin
            ready_ff <= ~ready_ff;
        end
    end

    // Input capture; the count saturates so long frames never look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ff  <= '0;
            cnt_ff <= 5'h00;
        end else if (frame_start) begin
            cnt_ff <= 5'h00;
        end else if (cap_edge) begin
            rx_ff  <= {rx_ff[FRAME_BITS-2:0], sdi_sync_ff[1]};
            cnt_ff <= (cnt_ff == 5'h1F) ? cnt_ff : cnt_ff + 5'h01;
        end
    end

    // Command decode at select rise
    wire        reg_frame = frame_end && (cnt_ff == REG_CLOCKS);
    wire [4:0]  opcode    = rx_ff[FRAME_BITS-1:OPC_LSB];
    wire [10:0] reg_addr  = rx_ff[OPC_LSB-1:ADDR_LSB];
    wire [7:0]  reg_data  = rx_ff[REG_BITS-1:0];
    wire        do_write  = reg_frame && (opcode == OPC_WRITE);
    wire        do_read   = reg_frame && (opcode == OPC_READ);
    wire [7:0]  in_val    = {6'h00, in_mode_ff};
    wire [7:0]  out_val   = {5'h00, width_ff, out_mode_ff};
    wire [7:0]  read_val  = (reg_addr == ADDR_IN_CTRL)  ? in_val
                          : (reg_addr == ADDR_OUT_CTRL) ? out_val : 8'h00;

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_mode_ff  <= PROTO_RESET;
            out_mode_ff <= OUT_PROTO_RESET;
            width_ff    <= OUT_WIDTH_RESET;
        end else if (do_write && reg_addr == ADDR_IN_CTRL) begin
            in_mode_ff  <= reg_data[1:0];
        end else if (do_write && reg_addr == ADDR_OUT_CTRL) begin
            out_mode_ff <= reg_data[1:0];
            width_ff    <= reg_data[OUT_WIDTH_BIT];
        end
    end

    // Read-back byte waits for the next frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_ff <= 1'b0;
            rd_byte_ff <= 8'h00;
        end else if (do_read) begin
            rd_pend_ff <= 1'b1;
            rd_byte_ff <= read_val;
        end else if (frame_start) begin
            rd_pend_ff <= 1'b0;
        end
    end

    // Two-entry result buffer; a slow host stalls the producer, no loss
    wire            push        = conv_valid & buf_ready_ff;
    wire [1:0]      nxt_buf_cnt = buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff    <= 1'b0;
            rd_ptr_ff    <= 1'b0;
            buf_cnt_ff   <= 2'h0;
            buf_ready_ff <= 1'b0;
        end else begin
            wr_ptr_ff    <= wr_ptr_ff ^ push;
            rd_ptr_ff    <= rd_ptr_ff ^ pop;
            buf_cnt_ff   <= nxt_buf_cnt;
            buf_ready_ff <= nxt_buf_cnt != 2'h2;
        end
    end

    // Buffer storage, no reset needed on data
    always_ff @(posedge pclk) begin
        if (push) begin
            buf_mem_ff[wr_ptr_ff] <= conv_data;
        end
    end

    // Outputs straight from flip-flops
    assign link.primary_output_lane_o    = lane0_ff;
    assign link.primary_output_lane_oe   = prim_oe_ff;
    assign link.secondary_output_lane_o  = lane1_ff;
    assign link.secondary_output_lane_oe = sec_oe_ff;
    assign link.ready_o                  = ready_ff;
    assign link.ready_oe                 = presetn_q_ff;
    assign conv_ready                    = buf_ready_ff;
    assign input_protocol_select         = in_mode_ff;
    assign output_protocol_select        = out_mode_ff;
    assign output_lane_width             = width_ff;

    // Ready pin is driven from the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presetn_q_ff <= 1'b0;
        end else begin
            presetn_q_ff <= 1'b1;
        end
    end

endmodule // spi_port_device

// [rtl/spi_port_host.sv]
`timescale 1ns/1ns
module spi_port_host #(
    parameter int SCLK_HALF = spi_port_pkg::SCLK_HALF_CYC
) (
    // Serial link
    spi_link_if.host         link,
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import spi_port_pkg::*;

    host_state_t           state_ff;
    logic [3:0]            div_ff;
    logic [5:0]            edge_ff;
    logic                  sclk_ff;
    logic                  cs_n_ff;
    logic                  sdi_ff;
    logic [FRAME_BITS-1:0] tx_ff;
    logic [FRAME_BITS-1:0] rx_ff;
    logic [12:0]           ctrl_ff;
    logic                  done_ff;
    logic [2:0]            rdy_sync_ff;
    logic [1:0]            l0_sync_ff;
    logic [1:0]            l1_sync_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;

    // APB decode
    wire setup    = psel & ~penable;
    wire access   = psel & penable & pready_ff;
    wire hit_cmd  = paddr == OFS_CMD;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_stat = paddr == OFS_STATUS;
    wire hit_rx   = paddr == OFS_RXDATA;
    wire mapped   = hit_cmd | hit_ctrl | hit_stat | hit_rx;
    wire busy     = state_ff != H_IDLE;
    wire start    = access & pwrite & hit_cmd & ~busy;
    wire [31:0] rd_mux = hit_ctrl ? {19'h0, ctrl_ff}
                       : hit_stat ? {30'h0, done_ff, busy}
                       : hit_rx   ? {8'h00, rx_ff} : 32'h0;

    // Frame settings
    wire [1:0] mode    = ctrl_ff[1:0];
    wire       dual    = ctrl_ff[CTRL_DUAL_BIT];
    wire       retime  = ctrl_ff[CTRL_RETIME_BIT];
    wire [5:0] last_ed = {ctrl_ff[CTRL_CLK_LSB+4:CTRL_CLK_LSB], 1'b0} - 6'h01;
    wire       tick    = div_ff == 4'h0;
    wire       do_edge = (state_ff == H_CLK) & tick;
    wire       first_c = ~edge_ff[0];
    wire       is_cap  = do_edge & (first_c ^ mode[0]);
    wire       is_lau  = do_edge & ~(first_c ^ mode[0]) & (edge_ff != 6'h00);
    wire       rdy_tgl = rdy_sync_ff[1] ^ rdy_sync_ff[2];
    wire       sample  = retime ? rdy_tgl & (state_ff == H_CLK || state_ff == H_TAIL)
                                : is_cap;

    // APB answer one cycle after setup; writes act at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
            ctrl_ff    <= {REG_CLOCKS, 8'h00};
        end else begin
            pready_ff  <= setup;
            prdata_ff  <= setup ? rd_mux : 32'h0;
            pslverr_ff <= setup & ~mapped;
            if (access && pwrite && hit_ctrl) begin
                ctrl_ff <= pwdata[12:0];
            end
        end
    end

    // Return lanes and ready are pins from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_sync_ff <= 3'h0;
            l0_sync_ff  <= 2'h0;
            l1_sync_ff  <= 2'h0;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[1:0], link.ready};
            l0_sync_ff  <= {l0_sync_ff[0], link.primary_output_lane};
            l1_sync_ff  <= {l1_sync_ff[0], link.secondary_output_lane};
        end
    end

    // Frame sequencer: lead half period, clock edges, tail half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= H_IDLE;
            div_ff   <= 4'h0;
            edge_ff  <= 6'h00;
            sclk_ff  <= 1'b0;
            cs_n_ff  <= 1'b1;
        end else begin
            div_ff <= (tick || state_ff == H_IDLE) ? 4'(SCLK_HALF - 1) : div_ff - 4'h1;
            unique case (state_ff)
                H_IDLE: begin
                    sclk_ff <= mode[1];
                    if (start) begin
                        cs_n_ff  <= 1'b0;
                        edge_ff  <= 6'h00;
                        state_ff <= H_LEAD;
                    end
                end
                H_LEAD: if (tick) begin
                    state_ff <= H_CLK;
                end
                H_CLK: if (tick) begin
                    sclk_ff <= ~sclk_ff;
                    edge_ff <= edge_ff + 6'h01;
                    if (edge_ff == last_ed) begin
                        state_ff <= H_TAIL;
                    end
                end
                H_TAIL: if (tick) begin
                    cs_n_ff  <= 1'b1;
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    // Command out MSB first, replies in; done is set by hardware only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ff   <= '0;
            sdi_ff  <= 1'b0;
            rx_ff   <= '0;
            done_ff <= 1'b0;
        end else begin
            if (start) begin
                sdi_ff <= pwdata[FRAME_BITS-1];
                tx_ff  <= {pwdata[FRAME_BITS-2:0], 1'b0};
            end else if (is_lau) begin
                sdi_ff <= tx_ff[FRAME_BITS-1];
                tx_ff  <= {tx_ff[FRAME_BITS-2:0], 1'b0};
            end
            if (sample) begin
                rx_ff <= dual ? {rx_ff[FRAME_BITS-3:0], l0_sync_ff[1], l1_sync_ff[1]}
                              : {rx_ff[FRAME_BITS-2:0], l0_sync_ff[1]};
            end
            if (state_ff == H_TAIL && tick) begin
                done_ff <= 1'b1;
            end else if (start) begin
                done_ff <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign link.sclk = sclk_ff;
    assign link.cs_n = cs_n_ff;
    assign link.sdi  = sdi_ff;
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;

endmodule // spi_port_host

// [sim/spi_link_asserts.sv]
`timescale 1ns/1ns
module spi_link_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host driven wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    // Device outputs and enables
    input wire logic primary_output_lane_o,
    input wire logic primary_output_lane_oe,
    input wire logic secondary_output_lane_o,
    input wire logic secondary_output_lane_oe,
    input wire logic ready_o,
    input wire logic ready_oe,
    input wire logic ready
);
    logic [5:0] sclk_hist_ff;
    logic [5:0] cs_hist_ff;
    logic       sclk_moved;
    logic       cs_moved;

    // Pin history, wide enough for the two-stage sampler plus output latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_hist_ff <= 6'h00;
            cs_hist_ff   <= 6'h3F;
        end else begin
            sclk_hist_ff <= {sclk_hist_ff[4:0], sclk};
            cs_hist_ff   <= {cs_hist_ff[4:0], cs_n};
        end
    end

    // A pin edge seen in the recent past
    assign sclk_moved = (sclk_hist_ff[5:1] != sclk_hist_ff[4:0]);
    assign cs_moved   = (cs_hist_ff[5:1] != cs_hist_ff[4:0]);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sclk_lead_a: assert property ($fell(cs_n) |-> $stable(sclk) [*8])
        else $error("serial clock moved during frame lead");
    sclk_half_a: assert property ($changed(sclk) && !cs_n |=> $stable(sclk) [*7])
        else $error("serial clock half period too short");
    ready_idle_a: assert property (cs_n [*8] |-> !ready)
        else $error("ready high between frames");
    oe_release_a: assert property (cs_n [*6] |-> !primary_output_lane_oe && !secondary_output_lane_oe)
        else $error("lanes still driven after frame end");
    msb_drive_a: assert property ($fell(cs_n) |-> ##[1:5] primary_output_lane_oe)
        else $error("primary lane not driven after select fall");
    lane_timing_a: assert property ($changed(primary_output_lane_o) && primary_output_lane_oe
        && $past(primary_output_lane_oe) |-> sclk_moved || cs_moved)
        else $error("primary lane changed away from a launch edge");
    dual_pair_a: assert property (secondary_output_lane_oe |-> primary_output_lane_oe)
        else $error("secondary lane driven alone");
    ready_edge_a: assert property ($changed(ready_o) |-> sclk_moved || cs_moved)
        else $error("ready toggled without a clock edge");
    ready_enable_a: assert property ($past(presetn) |-> ready_oe)
        else $error("ready pin not driven after reset");

    // Main scenarios reached
    cover property ($rose(secondary_output_lane_oe));
    cover property ($changed(ready_o));
    cover property ($fell(cs_n) && sclk);
endmodule // spi_link_asserts

// [sim/tb.sv]
`timescale 1ns/1ns
module tb;
    import spi_port_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] conv_data;
    logic        conv_valid;
    logic        conv_ready;
    logic [1:0]  in_sel;
    logic [1:0]  out_sel;
    logic        lane_w;
    logic        serr;
    int          err_count;
    int          n_compared;
    int          cyc;
    spi_link_if link_bus ();

    // Both ends face each other across one link
    spi_port_device u_spi_port_device (.link(link_bus), .pclk(pclk), .presetn(presetn),
        .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .input_protocol_select(in_sel), .output_protocol_select(out_sel),
        .output_lane_width(lane_w));
    spi_port_host u_spi_port_host (.link(link_bus), .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    spi_link_asserts u_spi_link_asserts (.pclk(pclk), .presetn(presetn),
        .sclk(link_bus.sclk), .cs_n(link_bus.cs_n), .sdi(link_bus.sdi),
        .primary_output_lane_o(link_bus.primary_output_lane_o),
        .primary_output_lane_oe(link_bus.primary_output_lane_oe),
        .secondary_output_lane_o(link_bus.secondary_output_lane_o),
        .secondary_output_lane_oe(link_bus.secondary_output_lane_oe),
        .ready_o(link_bus.ready_o), .ready_oe(link_bus.ready_oe), .ready(link_bus.ready));

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Hang guard, far above the longest expected run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (!link_bus.cs_n && out_sel == 2'h0) chk("ready", 32'h0, {31'h0, link_bus.ready});
        if (cyc == 60000) begin
            err_count = err_count + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until pready is sampled high; no latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q    = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic dl, input logic rt,
                                        input logic [4:0] n);
        return {19'h0, n, 4'h0, rt, dl, m};
    endfunction

    // One host frame; the extra wait covers the device's sampler and update delay
    task automatic frame(input logic [23:0] w, output logic [31:0] q);
        apb(1'b1, OFS_CMD, {8'h00, w}, q);
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, q);
        end while (q[STAT_DONE_BIT] !== 1'b1);
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_RXDATA, 32'h0, q);
    endtask

    task automatic push(input logic [15:0] w);
        @(posedge pclk);
        conv_data  <= w;
        conv_valid <= 1'b1;
        do begin
            @(posedge pclk);
        end while (conv_ready !== 1'b1);
        conv_valid <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        chk("cfg", 32'h0, {27'h0, lane_w, out_sel, in_sel});
        apb(1'b0, OFS_CTRL, 32'h0, q);
        chk("ctrl", ctl(2'h0, 1'b0, 1'b0, REG_CLOCKS), q);
        apb(1'b0, 8'h10, 32'h0, q);
        chk("slverr", 32'h1, {31'h0, serr});
    endtask

    task automatic t_short();
        logic [31:0] q;
        apb(1'b1, OFS_CTRL, ctl(2'h0, 1'b0, 1'b0, 5'h17), q);
        frame({OPC_WRITE, ADDR_IN_CTRL, 8'h01}, q);
        chk("short", 32'h0, {30'h0, in_sel});
        apb(1'b1, OFS_CTRL, ctl(2'h0, 1'b0, 1'b0, REG_CLOCKS), q);
    endtask

    // Each mode written in the old mode, then read back in the new one
    task automatic t_modes();
        logic [31:0] q;
        for (int m = 1; m <= 4; m++) begin
            frame({OPC_WRITE, ADDR_IN_CTRL, 8'(m % 4)}, q);
            apb(1'b1, OFS_CTRL, ctl(2'(m), 1'b0, 1'b0, REG_CLOCKS), q);
            chk("in_mode", 32'(m % 4), {30'h0, in_sel});
            frame({OPC_READ, ADDR_IN_CTRL, 8'h00}, q);
            frame(24'h000000, q);
            chk("reg_read", 32'(m % 4), {24'h0, q[23:16]});
        end
    endtask

    // Fill the buffer while nobody reads, then drain it
    task automatic t_conv();
        logic [31:0] q;
        push(16'hA5C3);
        push(16'h3C5A);
        @(posedge pclk);
        chk("full", 32'h0, {31'h0, conv_ready});
        frame(24'h000000, q);
        chk("conv0", 32'hA5C3, {16'h0, q[23:8]});
        frame(24'h000000, q);
        chk("conv1", 32'h3C5A, {16'h0, q[23:8]});
        frame(24'h000000, q);
        chk("empty", 32'h0, {16'h0, q[23:8]});
    endtask

    // Dual lane needs only twelve clocks for a 24-bit word
    task automatic t_dual();
        logic [31:0] q;
        frame({OPC_WRITE, ADDR_OUT_CTRL, 8'h04}, q);
        chk("width", 32'h1, {31'h0, lane_w});
        apb(1'b1, OFS_CTRL, ctl(2'h0, 1'b1, 1'b0, 5'h0C), q);
        push(16'h5A3C);
        frame(24'h000000, q);
        chk("dual", 32'h5A3C, {16'h0, q[23:8]});
        apb(1'b1, OFS_CTRL, ctl(2'h0, 1'b0, 1'b0, REG_CLOCKS), q);
        frame({OPC_WRITE, ADDR_OUT_CTRL, 8'h05}, q);
        chk("retime", 32'h1, {30'h0, out_sel});
        apb(1'b1, OFS_CTRL, ctl(2'h0, 1'b1, 1'b1, 5'h0C), q);
        push(16'hC3A5);
        frame(24'h000000, q);
        chk("rt_dual", 32'hC3A5, {16'h0, q[23:8]});
    endtask

    // Main sequence
    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        conv_data  = 16'h0000;
        conv_valid = 1'b0;
        err_count  = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_short();
        t_modes();
        t_conv();
        t_dual();
        end_of_test();
    end
endmodule // tb
